/* File: rcpoc_pkg.sv */
// package for the reset cause and supply-rise clear block
// assumes a single 40 MHz cpu clock domain
package rcpoc_pkg;
   // ***************************
   // cause register layout
   // ***************************
   localparam int RCPOC_UV_BIT = 0;
   localparam int RCPOC_WD_BIT = 4;
   localparam logic [7:0] RCPOC_CAUSE_RESET = 8'h00;
   // ***************************
   // timing
   // ***************************
   localparam int RCPOC_CLK_HZ = 40000000;
   localparam int RCPOC_CLK_PERIOD_NS = 25;
   localparam int RCPOC_RISE_WINDOW_US = 1930;
   localparam int RCPOC_STAB_MAX_US = 5390;
   // longest times round down
   localparam int RCPOC_RISE_WINDOW_CYC = (RCPOC_RISE_WINDOW_US * 1000) / RCPOC_CLK_PERIOD_NS;
   localparam int RCPOC_STAB_MAX_CYC = (RCPOC_STAB_MAX_US * 1000) / RCPOC_CLK_PERIOD_NS;
   localparam int RCPOC_CNT_W = 18;
   typedef enum logic [1:0] {RCPOC_HOLD, RCPOC_RISING, RCPOC_STAB, RCPOC_RUN} rcpoc_state_t;
endpackage

/* File: rcpoc_cause_if.sv */
// carrier between the sequencer and the cause register
// assumes both ends share clk
`timescale 1ns/1ps
interface rcpoc_cause_if;
   logic clear;
   logic set_wd;
   logic set_uv;
   logic [7:0] value;
   modport seq (output clear, output set_wd, output set_uv, input value);
   modport reg_side (input clear, input set_wd, input set_uv, output value);
endinterface

/* File: rcpoc_cause_reg.sv */
// reset cause flag register
// assumes it is not reset by the internal reset, only by rstn
`timescale 1ns/1ps
module rcpoc_cause_reg
   import rcpoc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   rcpoc_cause_if.reg_side cif
);
   logic wd_q, wd_d, uv_q, uv_d;
   // ***************************
   // flag update
   // ***************************
   always_comb begin
      wd_d = wd_q;
      uv_d = uv_q;
      if (cif.clear) begin
         wd_d = 1'b0;
         uv_d = 1'b0;
      end
      // set wins over a same-cycle read clear; other flag held, but cleared by that read
      if (cif.set_wd) begin
         wd_d = 1'b1;
      end
      if (cif.set_uv) begin
         uv_d = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wd_q <= 1'b0;
         uv_q <= 1'b0;
      end else begin
         wd_q <= wd_d;
         uv_q <= uv_d;
      end
   end
   always_comb begin
      cif.value = RCPOC_CAUSE_RESET;
      cif.value[RCPOC_WD_BIT] = wd_q;
      cif.value[RCPOC_UV_BIT] = uv_q;
   end
   a_set_wd_flag: assert property (@(posedge clk) disable iff (!rstn)
      cif.set_wd |=> wd_q) else $error("watchdog flag not set");
   a_set_uv_flag: assert property (@(posedge clk) disable iff (!rstn)
      cif.set_uv |=> uv_q) else $error("undervoltage flag not set");
   a_hold_other: assert property (@(posedge clk) disable iff (!rstn)
      (cif.set_wd && !cif.set_uv && !cif.clear) |=> uv_q == $past(uv_q))
      else $error("undervoltage flag not held");
   a_hold_wd: assert property (@(posedge clk) disable iff (!rstn)
      (cif.set_uv && !cif.set_wd && !cif.clear) |=> wd_q == $past(wd_q))
      else $error("watchdog flag not held");
endmodule

/* File: rcpoc_top.sv */
// reset cause register and supply-rise clear sequencing
// assumes comparator and request inputs are synchronous to clk
// Notes on behaviour
// - cause register clears on reset pin and supply-rise clear, and on a read except a flag set that cycle
// - watchdog flag set on watchdog reset request, else zero
// - undervoltage flag set on monitor reset request, else zero
// - watchdog or undervoltage reset does not clear the other flag
// - select 0: hold reset until supply passes low threshold
// - select 1: hold reset until supply passes high threshold
// - below low threshold always resets; release per selected threshold
// - select 1 fast rise inserts stabilisation wait, bounded maximum
// - undervoltage flag sits at bit 0
`timescale 1ns/1ps
module rcpoc_top
   import rcpoc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic reset_pin_n,
   input wire logic power_rise_release_select,
   input wire logic above_rise_threshold_low,
   input wire logic above_rise_threshold_high,
   input wire logic watchdog_reset_req,
   input wire logic undervoltage_reset_req,
   input wire logic cause_read,
   output logic [7:0] reset_cause_flags,
   output logic internal_reset_n
);
   import rcpoc_pkg::*;
   rcpoc_cause_if cif ();
   rcpoc_state_t state_q, state_d;
   logic [RCPOC_CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] data_q, data_d;
   logic rst_n_q, rst_n_d;
   logic clear_src;
   logic [RCPOC_CNT_W-1:0] stab_len_q, stab_len_d;
   // ***************************
   // helpers
   // ***************************
   // fast rise: high threshold met before the window ran out
   function automatic logic in_rise_window(input logic [RCPOC_CNT_W-1:0] c);
      return c < RCPOC_CNT_W'(RCPOC_RISE_WINDOW_CYC);
   endfunction
   // ***************************
   // supply-rise clear sequencer
   // ***************************
   // time the rise window from crossing the low threshold; fast rise then adds the full wait, timed from the high one
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (!above_rise_threshold_low) begin
         state_d = RCPOC_HOLD;
         cnt_d = '0;
      end else begin
         unique case (state_q)
            RCPOC_HOLD: begin
               cnt_d = '0;
               if (!power_rise_release_select) begin
                  state_d = RCPOC_RUN;
               end else begin
                  state_d = RCPOC_RISING;
               end
            end
            RCPOC_RISING: begin
               if (above_rise_threshold_high) begin
                  if (in_rise_window(cnt_q)) begin
                     state_d = RCPOC_STAB;
                     cnt_d = '0;
                  end else begin
                     state_d = RCPOC_RUN;
                  end
               end else if (in_rise_window(cnt_q)) begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            RCPOC_STAB: begin
               // wait capped so it never exceeds the documented maximum
               if (cnt_q == RCPOC_CNT_W'(RCPOC_STAB_MAX_CYC - 1)) begin
                  state_d = RCPOC_RUN;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            RCPOC_RUN: begin
               state_d = RCPOC_RUN;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= RCPOC_HOLD;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end
   // ***************************
   // reset combine and cause
   // ***************************
   assign clear_src = !reset_pin_n || (state_q != RCPOC_RUN);
   assign cif.clear = clear_src || cause_read;
   // pin and supply clear dominate; they clear rather than record
   assign cif.set_wd = watchdog_reset_req && !clear_src;
   assign cif.set_uv = undervoltage_reset_req && !clear_src;
   always_comb begin
      rst_n_d = !(clear_src || watchdog_reset_req || undervoltage_reset_req);
      data_d = cif.value;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_n_q <= 1'b0;
         data_q <= RCPOC_CAUSE_RESET;
      end else begin
         rst_n_q <= rst_n_d;
         data_q <= data_d;
      end
   end
   assign internal_reset_n = rst_n_q;
   assign reset_cause_flags = data_q;
   rcpoc_cause_reg u_cause (
      .clk(clk),
      .rstn(rstn),
      .cif(cif)
   );
   // ***************************
   // checks
   // ***************************
   // separate count of wait cycles, so the bound is not judged by the sequencer count
   always_comb begin
      stab_len_d = '0;
      if (state_q == RCPOC_STAB) begin
         stab_len_d = stab_len_q;
         if (stab_len_q != '1) begin
            stab_len_d = stab_len_q + 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stab_len_q <= '0;
      end else begin
         stab_len_q <= stab_len_d;
      end
   end
   // comparator acts through the state, so the output follows two edges later
   a_low_forces_reset: assert property (@(posedge clk) disable iff (!rstn)
      !above_rise_threshold_low |-> ##2 !internal_reset_n)
      else $error("reset not held below low threshold");
   a_low_to_hold: assert property (@(posedge clk) disable iff (!rstn)
      !above_rise_threshold_low |=> state_q == RCPOC_HOLD)
      else $error("sequencer not back in hold");
   a_mode0_release: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_HOLD && above_rise_threshold_low && !power_rise_release_select)
      |=> state_q == RCPOC_RUN) else $error("mode 0 release missing");
   a_mode1_enter: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_HOLD && above_rise_threshold_low && power_rise_release_select)
      |=> state_q == RCPOC_RISING) else $error("mode 1 left the hold early");
   a_mode1_hold: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_RISING && !above_rise_threshold_high) |=> state_q != RCPOC_RUN)
      else $error("mode 1 released early");
   a_slow_rise_run: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_RISING && above_rise_threshold_low && above_rise_threshold_high
      && !in_rise_window(cnt_q)) |=> state_q == RCPOC_RUN)
      else $error("slow rise not released");
   a_fast_rise_wait: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_RISING && above_rise_threshold_low && above_rise_threshold_high
      && in_rise_window(cnt_q)) |=> state_q == RCPOC_STAB)
      else $error("fast rise skipped the wait");
   a_window_saturates: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_RISING && above_rise_threshold_low && !above_rise_threshold_high
      && !in_rise_window(cnt_q)) |=> $stable(cnt_q))
      else $error("rise window count wrapped");
   a_stab_holds: assert property (@(posedge clk) disable iff (!rstn)
      state_q == RCPOC_STAB |=> !internal_reset_n)
      else $error("reset released during the wait");
   a_stab_bound: assert property (@(posedge clk) disable iff (!rstn)
      state_q == RCPOC_STAB |-> stab_len_q < RCPOC_CNT_W'(RCPOC_STAB_MAX_CYC))
      else $error("stabilisation wait too long");
   a_stab_exit: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_STAB && above_rise_threshold_low
      && stab_len_q == RCPOC_CNT_W'(RCPOC_STAB_MAX_CYC - 1)) |=> state_q == RCPOC_RUN)
      else $error("wait did not end at its maximum");
   a_run_stays: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == RCPOC_RUN && above_rise_threshold_low) |=> state_q == RCPOC_RUN)
      else $error("sequencer left run with supply up");
   a_release_from_run: assert property (@(posedge clk) disable iff (!rstn)
      internal_reset_n |-> $past(state_q) == RCPOC_RUN)
      else $error("reset released outside run");
   a_pin_source: assert property (@(posedge clk) disable iff (!rstn)
      !reset_pin_n |=> !internal_reset_n)
      else $error("reset pin did not reset");
   a_watch_source: assert property (@(posedge clk) disable iff (!rstn)
      watchdog_reset_req |=> !internal_reset_n)
      else $error("watchdog request did not reset");
   a_uv_source: assert property (@(posedge clk) disable iff (!rstn)
      undervoltage_reset_req |=> !internal_reset_n)
      else $error("undervoltage request did not reset");
   a_read_clears: assert property (@(posedge clk) disable iff (!rstn)
      (cause_read && !watchdog_reset_req && !undervoltage_reset_req) ##1
      (!watchdog_reset_req && !undervoltage_reset_req) |=> reset_cause_flags == 8'h00)
      else $error("read did not clear");
   a_pin_clears: assert property (@(posedge clk) disable iff (!rstn)
      !reset_pin_n ##1 !reset_pin_n |=> reset_cause_flags == 8'h00)
      else $error("pin did not clear");
   a_hold_clears: assert property (@(posedge clk) disable iff (!rstn)
      state_q != RCPOC_RUN ##1 state_q != RCPOC_RUN |=> reset_cause_flags == 8'h00)
      else $error("supply clear did not clear");
   a_watch_flag_out: assert property (@(posedge clk) disable iff (!rstn)
      (watchdog_reset_req && !clear_src) |-> ##2 reset_cause_flags[RCPOC_WD_BIT])
      else $error("watchdog flag not shown");
   a_uv_flag_out: assert property (@(posedge clk) disable iff (!rstn)
      (undervoltage_reset_req && !clear_src) |-> ##2 reset_cause_flags[RCPOC_UV_BIT])
      else $error("undervoltage flag not shown");
   a_spare_bits_zero: assert property (@(posedge clk) disable iff (!rstn)
      {reset_cause_flags[7:5], reset_cause_flags[3:1]} == 6'h00)
      else $error("unused cause bits not zero");
endmodule

/* File: rcpoc_src_model.sv */
// reset source model: pin, supply comparators, watchdog and monitor requests
// assumes the bench calls its tasks; every change lands just after a clk edge
`timescale 1ns/1ps
module rcpoc_src_model (
   input wire logic clk,
   output logic pin_n,
   output logic sup_lo,
   output logic sup_hi,
   output logic wd_req,
   output logic uv_req
);
   initial begin
      pin_n = 1'b1;
      sup_lo = 1'b0;
      sup_hi = 1'b0;
      wd_req = 1'b0;
      uv_req = 1'b0;
   end
   // high comparator cannot be above while the low one is below
   task automatic supply(input logic lo, input logic hi);
      @(posedge clk);
      sup_lo <= lo;
      sup_hi <= hi & lo;
   endtask
   task automatic pin(input logic v);
      @(posedge clk);
      pin_n <= v;
   endtask
   // one-cycle request from the watchdog or the monitor
   task automatic req(input logic wd);
      @(posedge clk);
      wd_req <= wd;
      uv_req <= ~wd;
      @(posedge clk);
      wd_req <= 1'b0;
      uv_req <= 1'b0;
   endtask
endmodule

/* File: rcpoc_top_tb.sv */
// self-checking bench for the reset cause and supply-rise clear block
// assumes the fixed 77200 cycle rise window; no monitor setup in reset
`timescale 1ns/1ps
module rcpoc_top_tb;
   import rcpoc_pkg::*;
   logic clk;
   logic rstn;
   logic sel;
   logic rd;
   logic pin_n, lo, hi, wd, uv, irn;
   logic [7:0] flags;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   rcpoc_src_model src_u (.clk(clk), .pin_n(pin_n), .sup_lo(lo), .sup_hi(hi),
      .wd_req(wd), .uv_req(uv));
   rcpoc_top dut_u (.clk(clk), .rstn(rstn), .reset_pin_n(pin_n),
      .power_rise_release_select(sel), .above_rise_threshold_low(lo),
      .above_rise_threshold_high(hi), .watchdog_reset_req(wd),
      .undervoltage_reset_req(uv), .cause_read(rd), .reset_cause_flags(flags),
      .internal_reset_n(irn));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // a cut-off well past the slow mode-1 rise keeps a hang from running forever
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t exp=%0h got=%0h", $time, exp, got);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic mode);
      @(posedge clk);
      rstn <= 1'b0;
      sel <= mode;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
   endtask
   task automatic t_mode1();
      do_reset(1'b1);
      src_u.supply(1'b1, 1'b0);
      wait_cyc(200);
      chk(8'h00, {7'h00, irn});
      wait_cyc(77500);
      src_u.supply(1'b1, 1'b1);
      wait_cyc(4);
      chk(8'h01, {7'h00, irn});
      src_u.supply(1'b0, 1'b0);
      wait_cyc(3);
      chk(8'h00, {7'h00, irn});
      src_u.supply(1'b1, 1'b0);
      wait_cyc(20);
      chk(8'h00, {7'h00, irn});
   endtask
   // fast mode-1 rise: the wait holds reset and refuses flags, even a watchdog request mid-wait
   task automatic t_fast_rise();
      do_reset(1'b1);
      wait_cyc(2);
      chk(8'h00, flags);
      chk(8'h00, {7'h00, irn});
      src_u.supply(1'b1, 1'b0);
      wait_cyc(10);
      src_u.supply(1'b1, 1'b1);
      wait_cyc(1000);
      chk(8'h00, {7'h00, irn});
      src_u.req(1'b1);
      wait_cyc(3);
      chk(8'h00, flags);
      chk(8'h00, {7'h00, irn});
   endtask
   task automatic t_mode0();
      src_u.supply(1'b0, 1'b0);
      do_reset(1'b0);
      wait_cyc(10);
      chk(8'h00, {7'h00, irn});
      src_u.supply(1'b1, 1'b0);
      wait_cyc(4);
      chk(8'h01, {7'h00, irn});
      chk(RCPOC_CAUSE_RESET, flags);
   endtask
   task automatic t_flags();
      src_u.req(1'b1);
      #1;
      chk(8'h00, {7'h00, irn});
      wait_cyc(3);
      chk(8'h10, flags);
      src_u.req(1'b0);
      wait_cyc(3);
      chk(8'h11, flags);
      @(posedge clk);
      rd <= 1'b1; // full byte read only
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(8'h11, flags);
      wait_cyc(1);
      chk(8'h00, flags);
      src_u.req(1'b1);
      wait_cyc(3);
      src_u.pin(1'b0);
      wait_cyc(3);
      chk(8'h00, flags);
      chk(8'h00, {7'h00, irn});
      src_u.pin(1'b1);
      wait_cyc(4);
      src_u.req(1'b1);
      wait_cyc(3);
      chk(8'h10, flags);
      src_u.supply(1'b0, 1'b0);
      wait_cyc(3);
      chk(8'h00, flags);
      src_u.supply(1'b1, 1'b0);
      wait_cyc(4);
      chk(8'h01, {7'h00, irn});
   endtask
   // software would wait out supply ripple here before port setup
   initial begin
      rstn = 1'b0;
      sel = 1'b0;
      rd = 1'b0;
      t_mode1();
      t_fast_rise();
      t_mode0();
      t_flags();
      print_verdict();
   end
endmodule
